// File: rtl/srf_formatter.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Function
// R01 - Status word sent as four hex characters
// R02 - Bit 0 flags uncompensated part only
// R03 - Bits 1-7 flag compensation arithmetic faults
// R04 - Out-of-range pressure clamped, bit 8 set
// R05 - Bits 9-15 reserved, no error meaning
// R06 - Serial mismatch on addressed command: silence
// R07 - Serial string twelve chars, fixed pattern
// R08 - Pressure range: low to high units mode
// R09 - Temperature range: low high C
// R10 - Pressure reply: echo, equals, hex, status, CR
// R11 - Non-limit error forces pressure to 8000
// R12 - Every message ends with carriage return
// R13 - Addressed reply: U, serial, space, reply
// R14 - Hex digits A-F sent uppercase
// R15 - Reserved status bits sent as zero
module srf_formatter
    import srf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire srf_bus_req_t bus_req,
    output logic [31:0] rd_data,
    input wire logic cmd_valid,
    input wire srf_cmd_req_t cmd,
    output logic cmd_ready,
    input wire logic sample_valid,
    input wire srf_sample_t sample,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Nibble to uppercase hex character
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        if (n < 4'ha) begin
            hex_char = SRF_CH_0 + {4'h0, n};
        end else begin
            hex_char = SRF_CH_A + {4'h0, n - 4'ha}; // [R14]
        end
    endfunction : hex_char

    // Two decimal digits of a value below 100
    function automatic logic [15:0] dec2(input logic [6:0] v);
        logic [6:0] t;
        logic [6:0] o;
        t = v / 7'd10;
        o = v % 7'd10;
        dec2 = {SRF_CH_0 + {1'b0, t}, SRF_CH_0 + {1'b0, o}};
    endfunction : dec2

    // Character i of the serial string built from packed fields
    function automatic logic [7:0] sn_char(input logic [31:0] f,
                                           input logic [3:0] i);
        logic [15:0] d;
        logic [3:0] m;
        d = 16'h0000;
        m = f[7:4];
        sn_char = SRF_CH_DASH;
        unique case (i) // [R07]
            4'h0: sn_char = SRF_CH_0 + {4'h0, f[3:0]};
            4'h1: sn_char = SRF_CH_A + {4'h0, m}
                + ((m >= SRF_MONTH_SKIP) ? 8'h01 : 8'h00);
            4'h2: begin
                d = dec2({2'b00, f[12:8]});
                sn_char = d[15:8];
            end
            4'h3: begin
                d = dec2({2'b00, f[12:8]});
                sn_char = d[7:0];
            end
            4'h5: begin
                d = dec2(f[19:13]);
                sn_char = d[15:8];
            end
            4'h6: begin
                d = dec2(f[19:13]);
                sn_char = d[7:0];
            end
            4'h8: sn_char = SRF_CH_A + {3'h0, f[24:20]};
            4'h9: sn_char = SRF_CH_0 + {5'h00, f[27:25]};
            4'ha: begin
                d = dec2({3'h0, f[31:28]});
                sn_char = d[15:8];
            end
            4'hb: begin
                d = dec2({3'h0, f[31:28]});
                sn_char = d[7:0];
            end
            default: sn_char = SRF_CH_DASH;
        endcase
    endfunction : sn_char

    // Character i of a four-character word, first character on top
    function automatic logic [7:0] word_char(input logic [31:0] w,
                                             input logic [4:0] i);
        word_char = w[31 - 8 * i[1:0] -: 8];
    endfunction : word_char

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0] ctrl_ff, serial_ff, plimit_ff, pr_lo_ff, pr_hi_ff;
    logic [31:0] punits_ff, tr_lo_ff, tr_hi_ff, rd_data_ff;
    logic [31:0] nxt_ctrl, nxt_serial, nxt_plimit, nxt_pr_lo, nxt_pr_hi;
    logic [31:0] nxt_punits, nxt_tr_lo, nxt_tr_hi, nxt_rd_data;
    logic [SRF_IRQ_W-1:0] irq_st_ff, irq_mask_ff, nxt_irq_st, nxt_irq_mask;
    logic irq_ff, nxt_irq;
    logic [15:0] live_press_ff, live_stat_ff, nxt_live_press, nxt_live_stat;
    logic [15:0] cap_press_ff, cap_stat_ff, nxt_cap_press, nxt_cap_stat;
    logic [15:0] rep_press_ff, rep_stat_ff, nxt_rep_press, nxt_rep_stat;
    srf_state_t state_ff, nxt_state;
    srf_cmd_t kind_ff, nxt_kind;
    logic [4:0] idx_ff, nxt_idx;
    logic tx_valid_ff, nxt_tx_valid, cmd_ready_ff, nxt_cmd_ready;
    logic [7:0] tx_data_ff, nxt_tx_data;
    logic ev_done, ev_mute, ev_err;
    logic [7:0] cur_char;
    logic [15:0] echo;

    // ------------------------------------------------------------------
    // Register file and interrupts
    // ------------------------------------------------------------------
    // Writes, reads, sticky events with set winning over read-clear
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_serial = serial_ff;
        nxt_plimit = plimit_ff;
        nxt_pr_lo = pr_lo_ff;
        nxt_pr_hi = pr_hi_ff;
        nxt_punits = punits_ff;
        nxt_tr_lo = tr_lo_ff;
        nxt_tr_hi = tr_hi_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_st = irq_st_ff;
        nxt_rd_data = SRF_WORD_RST;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                SRF_REG_CTRL: nxt_ctrl = bus_req.wdata;
                SRF_REG_SERIAL: nxt_serial = bus_req.wdata;
                SRF_REG_PLIMIT: nxt_plimit = bus_req.wdata;
                SRF_REG_PR_LO: nxt_pr_lo = bus_req.wdata;
                SRF_REG_PR_HI: nxt_pr_hi = bus_req.wdata;
                SRF_REG_PUNITS: nxt_punits = bus_req.wdata;
                SRF_REG_TR_LO: nxt_tr_lo = bus_req.wdata;
                SRF_REG_TR_HI: nxt_tr_hi = bus_req.wdata;
                SRF_REG_IRQ_MASK: nxt_irq_mask = bus_req.wdata[2:0];
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                SRF_REG_CTRL: nxt_rd_data = ctrl_ff;
                SRF_REG_SERIAL: nxt_rd_data = serial_ff;
                SRF_REG_PLIMIT: nxt_rd_data = plimit_ff;
                SRF_REG_PR_LO: nxt_rd_data = pr_lo_ff;
                SRF_REG_PR_HI: nxt_rd_data = pr_hi_ff;
                SRF_REG_PUNITS: nxt_rd_data = punits_ff;
                SRF_REG_TR_LO: nxt_rd_data = tr_lo_ff;
                SRF_REG_TR_HI: nxt_rd_data = tr_hi_ff;
                SRF_REG_STATUS: nxt_rd_data = {16'h0000, live_stat_ff};
                SRF_REG_IRQ_ST: begin
                    nxt_rd_data = {29'h0, irq_st_ff};
                    nxt_irq_st = '0;
                end
                SRF_REG_IRQ_MASK: nxt_rd_data = {29'h0, irq_mask_ff};
                default: nxt_rd_data = SRF_WORD_RST;
            endcase
        end
        nxt_irq_st = nxt_irq_st | {ev_err, ev_mute, ev_done};
        nxt_irq = |(nxt_irq_st & nxt_irq_mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff <= SRF_CTRL_RST;
            serial_ff <= SRF_WORD_RST;
            plimit_ff <= SRF_PLIMIT_RST;
            pr_lo_ff <= SRF_WORD_RST;
            pr_hi_ff <= SRF_WORD_RST;
            punits_ff <= SRF_WORD_RST;
            tr_lo_ff <= SRF_WORD_RST;
            tr_hi_ff <= SRF_WORD_RST;
            irq_mask_ff <= '0;
            irq_st_ff <= '0;
            irq_ff <= 1'b0;
            rd_data_ff <= SRF_WORD_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            serial_ff <= nxt_serial;
            plimit_ff <= nxt_plimit;
            pr_lo_ff <= nxt_pr_lo;
            pr_hi_ff <= nxt_pr_hi;
            punits_ff <= nxt_punits;
            tr_lo_ff <= nxt_tr_lo;
            tr_hi_ff <= nxt_tr_hi;
            irq_mask_ff <= nxt_irq_mask;
            irq_st_ff <= nxt_irq_st;
            irq_ff <= nxt_irq;
            rd_data_ff <= nxt_rd_data;
        end
    end

    // ------------------------------------------------------------------
    // Status word and pressure conditioning
    // ------------------------------------------------------------------
    // Build status, clamp to limits, force error code
    always_comb begin
        logic [15:0] st;
        logic signed [15:0] p;
        logic signed [15:0] hi;
        logic signed [15:0] lo;
        st = SRF_STAT_RST; // [R05] [R15]
        p = sample.press;
        hi = plimit_ff[31:16];
        lo = plimit_ff[15:0];
        st[SRF_ST_UNCAL] = ~ctrl_ff[SRF_CTRL_CAL]; // [R02]
        st[SRF_ST_FAULT +: 7] = sample.faults; // [R03]
        if (p > hi) begin
            p = hi; // [R04]
            st[SRF_ST_LIMIT] = 1'b1;
        end else if (p < lo) begin
            p = lo; // [R04]
            st[SRF_ST_LIMIT] = 1'b1;
        end
        nxt_live_press = live_press_ff;
        nxt_live_stat = {live_stat_ff[15:1], st[SRF_ST_UNCAL]}; // [R02]
        ev_err = 1'b0;
        if (sample_valid) begin
            nxt_live_stat = st; // [R01]
            nxt_live_press = (|st[7:0]) ? SRF_PRESS_ERR : p; // [R11]
            ev_err = |st;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            live_press_ff <= SRF_PRESS_ERR;
            live_stat_ff <= SRF_STAT_RST;
        end else begin
            live_press_ff <= nxt_live_press;
            live_stat_ff <= nxt_live_stat;
        end
    end

    // ------------------------------------------------------------------
    // Reply character selection
    // ------------------------------------------------------------------
    // Zero means an empty slot that is skipped
    always_comb begin
        unique case (kind_ff)
            SRF_CMD_LORES: echo = SRF_ECHO_LO;
            SRF_CMD_CAPTD: echo = SRF_ECHO_CAP;
            SRF_CMD_SERIAL: echo = SRF_ECHO_SN;
            SRF_CMD_PRANGE: echo = SRF_ECHO_PR;
            SRF_CMD_TRANGE: echo = SRF_ECHO_TR;
            default: echo = SRF_ECHO_HI;
        endcase
        cur_char = SRF_CH_CR; // [R12]
        if (state_ff == SRF_PREFIX) begin
            if (idx_ff == 5'h00) begin
                cur_char = SRF_CH_U; // [R13]
            end else if (idx_ff == SRF_PREFIX_LAST) begin
                cur_char = SRF_CH_SP; // [R13]
            end else begin
                cur_char = sn_char(serial_ff, 4'(idx_ff - 5'h01));
            end
        end else if (idx_ff == 5'h00) begin
            cur_char = echo[15:8]; // [R10]
        end else if (idx_ff == 5'h01) begin
            cur_char = echo[7:0];
        end else if (idx_ff == 5'h02) begin
            cur_char = SRF_CH_EQ;
        end else begin
            unique case (kind_ff)
                SRF_CMD_SERIAL: if (idx_ff < 5'h0f) begin
                    cur_char = sn_char(serial_ff, 4'(idx_ff - 5'h03));
                end
                SRF_CMD_PRANGE: begin // [R08]
                    if (idx_ff < 5'h07) begin
                        cur_char = word_char(pr_lo_ff, idx_ff - 5'h03);
                    end else if (idx_ff == 5'h07 || idx_ff == 5'h0a
                                 || idx_ff == 5'h0f) begin
                        cur_char = SRF_CH_SP;
                    end else if (idx_ff == 5'h08) begin
                        cur_char = SRF_CH_T;
                    end else if (idx_ff == 5'h09) begin
                        cur_char = SRF_CH_O;
                    end else if (idx_ff < 5'h0f) begin
                        cur_char = word_char(pr_hi_ff, idx_ff - 5'h0b);
                    end else if (idx_ff < 5'h14) begin
                        cur_char = word_char(punits_ff, idx_ff - 5'h10);
                    end else if (idx_ff == 5'h14) begin
                        unique case (ctrl_ff[SRF_CTRL_MODE +: 2])
                            2'h1: cur_char = SRF_CH_D;
                            2'h2: cur_char = SRF_CH_G;
                            default: cur_char = SRF_CH_A;
                        endcase
                    end
                end
                SRF_CMD_TRANGE: begin // [R09]
                    if (idx_ff < 5'h07) begin
                        cur_char = word_char(tr_lo_ff, idx_ff - 5'h03);
                    end else if (idx_ff == 5'h07 || idx_ff == 5'h0c) begin
                        cur_char = SRF_CH_SP;
                    end else if (idx_ff < 5'h0c) begin
                        cur_char = word_char(tr_hi_ff, idx_ff - 5'h08);
                    end else if (idx_ff == 5'h0d) begin
                        cur_char = SRF_CH_C;
                    end
                end
                default: begin // [R10] [R01]
                    if (idx_ff < 5'h07) begin
                        cur_char = hex_char(rep_press_ff[4'(5'h06 - idx_ff)
                            * 4 +: 4]);
                    end else if (idx_ff == 5'h07) begin
                        cur_char = SRF_CH_SP;
                    end else if (idx_ff < 5'h0c) begin
                        cur_char = hex_char(rep_stat_ff[4'(5'h0b - idx_ff)
                            * 4 +: 4]);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Command acceptance and transmit sequencing
    // ------------------------------------------------------------------
    always_comb begin
        logic mismatch;
        logic can_load;
        mismatch = 1'b0;
        can_load = ~tx_valid_ff | tx_ready;
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_idx = idx_ff;
        nxt_cap_press = cap_press_ff;
        nxt_cap_stat = cap_stat_ff;
        nxt_rep_press = rep_press_ff;
        nxt_rep_stat = rep_stat_ff;
        nxt_tx_valid = tx_valid_ff & ~tx_ready;
        nxt_tx_data = tx_data_ff;
        nxt_cmd_ready = cmd_ready_ff | (state_ff == SRF_IDLE);
        ev_done = 1'b0;
        ev_mute = 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (sn_char(serial_ff, 4'(i)) != cmd.sn[i]) begin
                mismatch = 1'b1;
            end
        end
        unique case (state_ff)
            SRF_IDLE: if (cmd_valid && cmd_ready_ff) begin
                nxt_kind = cmd.kind;
                nxt_idx = 5'h00;
                nxt_cmd_ready = 1'b0;
                if (cmd.addressed && mismatch) begin
                    ev_mute = 1'b1; // [R06]
                end else if (cmd.kind == SRF_CMD_CAPTURE) begin
                    nxt_cap_press = live_press_ff;
                    nxt_cap_stat = live_stat_ff;
                end else if (ctrl_ff[SRF_CTRL_EN]) begin
                    nxt_rep_stat = live_stat_ff;
                    nxt_rep_press = live_press_ff;
                    if (cmd.kind == SRF_CMD_CAPTD) begin
                        nxt_rep_stat = cap_stat_ff;
                        nxt_rep_press = cap_press_ff;
                    end else if (cmd.kind == SRF_CMD_LORES &&
                                 live_press_ff != SRF_PRESS_ERR) begin
                        nxt_rep_press = 16'($signed(live_press_ff)
                            >>> SRF_LORES_SHIFT);
                    end
                    nxt_state = cmd.addressed ? SRF_PREFIX : SRF_BODY;
                end
            end
            default: if (can_load) begin
                nxt_idx = idx_ff + 5'h01;
                if (cur_char != 8'h00) begin
                    nxt_tx_valid = 1'b1;
                    nxt_tx_data = cur_char;
                end
                if (state_ff == SRF_PREFIX && idx_ff == SRF_PREFIX_LAST) begin
                    nxt_state = SRF_BODY;
                    nxt_idx = 5'h00;
                end else if (state_ff == SRF_BODY &&
                             cur_char == SRF_CH_CR) begin
                    nxt_state = SRF_IDLE; // [R12]
                    nxt_cmd_ready = 1'b1;
                    ev_done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= SRF_IDLE;
            kind_ff <= SRF_CMD_HIRES;
            idx_ff <= 5'h00;
            cap_press_ff <= SRF_PRESS_ERR;
            cap_stat_ff <= SRF_STAT_RST;
            rep_press_ff <= SRF_PRESS_ERR;
            rep_stat_ff <= SRF_STAT_RST;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            cmd_ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            idx_ff <= nxt_idx;
            cap_press_ff <= nxt_cap_press;
            cap_stat_ff <= nxt_cap_stat;
            rep_press_ff <= nxt_rep_press;
            rep_stat_ff <= nxt_rep_stat;
            tx_valid_ff <= nxt_tx_valid;
            tx_data_ff <= nxt_tx_data;
            cmd_ready_ff <= nxt_cmd_ready;
        end
    end

    assign rd_data = rd_data_ff;
    assign irq = irq_ff;
    assign tx_valid = tx_valid_ff;
    assign tx_data = tx_data_ff;
    assign cmd_ready = cmd_ready_ff;

endmodule : srf_formatter

`default_nettype wire

// File: rtl/srf_pkg.sv
package srf_pkg;

    // ------------------------------------------------------------------
    // Register map, word offsets on the plain register port
    // ------------------------------------------------------------------
    localparam int SRF_AW = 4;
    localparam logic [3:0] SRF_REG_CTRL = 4'h0;
    localparam logic [3:0] SRF_REG_SERIAL = 4'h1;
    localparam logic [3:0] SRF_REG_PLIMIT = 4'h2;
    localparam logic [3:0] SRF_REG_PR_LO = 4'h3;
    localparam logic [3:0] SRF_REG_PR_HI = 4'h4;
    localparam logic [3:0] SRF_REG_PUNITS = 4'h5;
    localparam logic [3:0] SRF_REG_TR_LO = 4'h6;
    localparam logic [3:0] SRF_REG_TR_HI = 4'h7;
    localparam logic [3:0] SRF_REG_STATUS = 4'h8;
    localparam logic [3:0] SRF_REG_IRQ_ST = 4'h9;
    localparam logic [3:0] SRF_REG_IRQ_MASK = 4'ha;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int SRF_CTRL_EN = 0;
    localparam int SRF_CTRL_CAL = 1;
    localparam int SRF_CTRL_MODE = 2;
    localparam logic [31:0] SRF_CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] SRF_WORD_RST = 32'h0000_0000;
    localparam logic [31:0] SRF_PLIMIT_RST = 32'h7fff_8000;
    localparam int SRF_ST_UNCAL = 0;
    localparam int SRF_ST_FAULT = 1;
    localparam int SRF_ST_LIMIT = 8;
    localparam logic [15:0] SRF_STAT_RST = 16'h0000;
    localparam logic [15:0] SRF_PRESS_ERR = 16'h8000;
    localparam int SRF_IRQ_W = 3;
    localparam int SRF_IRQ_DONE = 0;
    localparam int SRF_IRQ_MUTE = 1;
    localparam int SRF_IRQ_ERR = 2;
    localparam logic [4:0] SRF_PREFIX_LAST = 5'h0d;
    localparam logic [1:0] SRF_LORES_SHIFT = 2'h2;

    // ------------------------------------------------------------------
    // Characters
    // ------------------------------------------------------------------
    localparam logic [7:0] SRF_CH_CR = 8'h0d;
    localparam logic [7:0] SRF_CH_SP = 8'h20;
    localparam logic [7:0] SRF_CH_EQ = 8'h3d;
    localparam logic [7:0] SRF_CH_DASH = 8'h2d;
    localparam logic [7:0] SRF_CH_0 = 8'h30;
    localparam logic [7:0] SRF_CH_A = 8'h41;
    localparam logic [7:0] SRF_CH_C = 8'h43;
    localparam logic [7:0] SRF_CH_D = 8'h44;
    localparam logic [7:0] SRF_CH_G = 8'h47;
    localparam logic [7:0] SRF_CH_T = 8'h74;
    localparam logic [7:0] SRF_CH_O = 8'h6f;
    localparam logic [7:0] SRF_CH_U = 8'h55;
    localparam logic [3:0] SRF_MONTH_SKIP = 4'h8;
    localparam logic [15:0] SRF_ECHO_HI = 16'h5248;
    localparam logic [15:0] SRF_ECHO_LO = 16'h524c;
    localparam logic [15:0] SRF_ECHO_CAP = 16'h5243;
    localparam logic [15:0] SRF_ECHO_SN = 16'h5253;
    localparam logic [15:0] SRF_ECHO_PR = 16'h5252;
    localparam logic [15:0] SRF_ECHO_TR = 16'h5254;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {SRF_CMD_HIRES, SRF_CMD_LORES, SRF_CMD_CAPTD,
        SRF_CMD_SERIAL, SRF_CMD_PRANGE, SRF_CMD_TRANGE,
        SRF_CMD_CAPTURE} srf_cmd_t;
    typedef enum logic [1:0] {SRF_IDLE, SRF_PREFIX, SRF_BODY} srf_state_t;
    typedef struct packed {
        srf_cmd_t kind;
        logic addressed;
        logic [11:0][7:0] sn;
    } srf_cmd_req_t;
    typedef struct packed {
        logic signed [15:0] press;
        logic [6:0] faults;
    } srf_sample_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } srf_bus_req_t;

endpackage : srf_pkg

// File: bench/srf_formatter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module srf_formatter_asserts
    import srf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire srf_bus_req_t bus_req,
    input wire logic [31:0] rd_data,
    input wire logic cmd_valid,
    input wire srf_cmd_req_t cmd,
    input wire logic cmd_ready,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic take;
    logic rh;
    // Command handshake decode
    assign take = cmd_valid && cmd_ready;
    assign rh = take && cmd.kind == SRF_CMD_HIRES && !cmd.addressed;
    rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
        else $error("read data not zero while idle");
    tx_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data)) else $error("char not held");
    no_null_a: assert property (tx_valid |-> tx_data != 8'h00)
        else $error("empty slot sent");
    cr_end_a: assert property (tx_valid && tx_ready &&
        tx_data == SRF_CH_CR && !take |=> !tx_valid) else $error("after end");
    busy_take_a: assert property (tx_valid && tx_data != SRF_CH_CR
        |-> !cmd_ready) else $error("ready during reply");
    echo_start_a: assert property (rh |-> ##2 tx_valid &&
        tx_data == SRF_ECHO_HI[15:8]) else $error("bad first char");
    addr_lead_a: assert property (take && cmd.addressed |-> ##2
        !tx_valid || tx_data == SRF_CH_U) else $error("bad prefix");
    reply_end_a: assert property (rh |-> ##[1:60]
        tx_valid && tx_data == SRF_CH_CR) else $error("no end char");
    cover property (take && cmd.addressed);
    cover property (tx_valid && !tx_ready);
    cover property ($rose(irq));
endmodule : srf_formatter_asserts
bind srf_formatter srf_formatter_asserts u_chk (.clk(clk), .rst(rst),
    .bus_req(bus_req), .rd_data(rd_data), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .irq(irq));
`default_nettype wire

// File: bench/srf_host.sv
`timescale 1ns/1ps
`default_nettype none
module srf_host (
    input wire logic clk,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    string rx = "";
    initial tx_ready = 1'b1;
    // Collect reply chars; stall every other cycle when slow
    always @(posedge clk) begin
        if (tx_valid && tx_ready) rx = $sformatf("%s%c", rx, tx_data);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
endmodule : srf_host
`default_nettype wire

// File: bench/srf_formatter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srf_formatter_tb;
    import srf_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, sample_valid = 1'b0;
    logic slow = 1'b0, tx_ready, tx_valid, cmd_ready, irq;
    logic [7:0] tx_data;
    logic [31:0] rd_data, v;
    srf_bus_req_t bus_req = '0;
    srf_cmd_req_t cmd = '0;
    srf_sample_t sample = '0;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            conclude();
        end
    end
    srf_formatter dut (.clk(clk), .rst(rst), .bus_req(bus_req),
        .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .sample_valid(sample_valid),
        .sample(sample), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .irq(irq));
    srf_host host (.clk(clk), .slow(slow), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    task automatic cmps(string n, string e);
        cmp_count++;
        if (host.rx != e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %s got %s", n, e, host.rx);
        end
        host.rx = "";
    endtask : cmps
    task automatic wr(logic [3:0] a, logic [31:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rd(logic [3:0] a);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus_req <= '0;
        @(posedge clk);
        v = rd_data;
    endtask : rd
    task automatic samp(logic [15:0] p, logic [6:0] f);
        sample <= '{p, f};
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        @(posedge clk);
    endtask : samp
    task automatic send(srf_cmd_t k, logic ad, logic [95:0] s);
        cmd <= '{k, ad, s};
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 99 && cmd_ready !== 1'b1; i++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : send
    function automatic logic [95:0] sn_of(string s);
        logic [11:0][7:0] r;
        for (int i = 0; i < 12; i++) r[i] = s[i];
        return r;
    endfunction : sn_of
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(SRF_REG_CTRL);
        cmp("ctrl", 32'h1, v);
        rd(SRF_REG_PLIMIT);
        cmp("plimit", 32'h7fff8000, v);
        rd(SRF_REG_STATUS);
        cmp("status", 32'h1, v);
        rd(4'hf);
        cmp("unmapped", 32'h0, v);
        $display("test reset done");
        wr(SRF_REG_CTRL, 32'h3);
        wr(SRF_REG_PLIMIT, 32'h1000f000);
        samp(16'h2000, 7'h00);
        rd(SRF_REG_STATUS);
        cmp("status", 32'h100, v);
        send(SRF_CMD_HIRES, 1'b0, 96'h0);
        cmps("rh", "RH=1000 0100\r");
        send(SRF_CMD_LORES, 1'b0, 96'h0);
        cmps("rl", "RL=0400 0100\r");
        send(SRF_CMD_CAPTURE, 1'b0, 96'h0);
        slow <= 1'b1;
        samp(16'h0abc, 7'h05);
        send(SRF_CMD_HIRES, 1'b0, 96'h0);
        cmps("rh", "RH=8000 000A\r");
        send(SRF_CMD_CAPTD, 1'b0, 96'h0);
        cmps("rc", "RC=1000 0100\r");
        slow <= 1'b0;
        $display("test status done");
        wr(SRF_REG_SERIAL, 32'h32007733);
        send(SRF_CMD_SERIAL, 1'b0, 96'h0);
        cmps("rs", "RS=3D23-03-A103\r");
        wr(SRF_REG_IRQ_MASK, 32'h2);
        rd(SRF_REG_IRQ_ST);
        send(SRF_CMD_HIRES, 1'b1, sn_of("3D23-03-A104"));
        cmps("muted", "");
        cmp("irq", 32'h1, 32'(irq));
        rd(SRF_REG_IRQ_ST);
        cmp("irq_st", 32'h2, v & 32'h2);
        repeat (2) @(posedge clk);
        cmp("irq", 32'h0, 32'(irq));
        send(SRF_CMD_SERIAL, 1'b1, sn_of("3D23-03-A103"));
        cmps("urs", "U3D23-03-A103 RS=3D23-03-A103\r");
        $display("test address done");
        wr(SRF_REG_PR_LO, 32'h32300000);
        wr(SRF_REG_PR_HI, 32'h33320000);
        wr(SRF_REG_PUNITS, 32'h6d6d4867);
        for (int m = 0; m < 3; m++) begin
            wr(SRF_REG_CTRL, 32'h3 | (32'(m) << 2));
            send(SRF_CMD_PRANGE, 1'b0, 96'h0);
            cmps("rr", $sformatf("RR=20 to 32 mmHg%s\r",
                m == 0 ? "A" : m == 1 ? "D" : "G"));
        end
        wr(SRF_REG_TR_LO, 32'h2d323000);
        wr(SRF_REG_TR_HI, 32'h38350000);
        send(SRF_CMD_TRANGE, 1'b0, 96'h0);
        cmps("rt", "RT=-20 85 C\r");
        $display("test ranges done");
        conclude();
    end
endmodule : srf_formatter_tb
`default_nettype wire
